//--- include/refclk_cfg.svh
// Register offsets, field positions, reset values and divider widths for the reference clock divider.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
`ifndef REFCLK_CFG_SVH
`define REFCLK_CFG_SVH

`define REFCLK_CTRL_OFFSET   12'h000
`define REFCLK_STAT_OFFSET   12'h004
`define REFCLK_ADDR_LSB      2
`define REFCLK_ADDR_MSB      11

`define REFCLK_CTRL_RESET    8'h30

`define REFCLK_BIT_ON        7
`define REFCLK_BIT_ROUTE     6
`define REFCLK_BIT_SLEW      5
`define REFCLK_DUTY_MSB      4
`define REFCLK_DUTY_LSB      3
`define REFCLK_DIV_MSB       2
`define REFCLK_DIV_LSB       0

`define REFCLK_STAT_SRC_LSB  8
`define REFCLK_STAT_RUN_BIT  10

`define REFCLK_INSTR_DIV_W   2
`define REFCLK_MAX_DIV_EXP   7

`endif

//--- include/refclk_pkg.sv
// Types shared by the reference clock divider and its bench.
// Assumes refclk_cfg.svh is included alongside for numeric constants.
package refclk_pkg;

    typedef enum logic [1:0]
    {
        OSC_OTHER              = 2'h0,
        LOW_POWER_CRYSTAL_MODE = 2'h1,
        STANDARD_CRYSTAL_MODE  = 2'h2,
        HIGH_SPEED_CRYSTAL_MODE = 2'h3
    } osc_mode_t;

    typedef enum logic [1:0]
    {
        PIN_RELEASED = 2'h0,
        PIN_INSTR    = 2'h1,
        PIN_REFCLK   = 2'h2
    } pin_src_t;

    typedef enum logic [1:0]
    {
        BUS_IDLE  = 2'h0,
        BUS_READ  = 2'h1,
        BUS_WRITE = 2'h3
    } bus_state_t;

    typedef struct packed
    {
        logic       refclk_module_on;
        logic       refclk_pin_route;
        logic       pin_slew_limit;
        logic [1:0] duty_select;
        logic [2:0] divide_select;
    } ctrl_t;

    typedef struct packed
    {
        logic out;
        logic oe;
        logic slew;
    } pin_drive_t;

endpackage

//--- rtl/reference_clock_divider.sv
// Reference clock divider: AHB-Lite register slave, power-of-two divider, duty shaping, pin mux.
// Assumes config, sleep and bus inputs are synchronous to clk; clk is the system clock.
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "refclk_cfg.svh"

module reference_clock_divider
    import refclk_pkg::*;
#(
    parameter int CNT_W = `REFCLK_MAX_DIV_EXP
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire osc_mode_t   osc_mode,
    input  wire logic        instr_clock_out_ctrl,
    input  wire logic        sleep_req,
    output logic             modulator_clk,
    output logic             refclk_pin_out,
    output logic             refclk_pin_oe,
    output logic             pin_slew_limit_out
);

    initial
    begin
        if (CNT_W < `REFCLK_MAX_DIV_EXP)
            $error("Counter too narrow for divide by 128");
    end

    ctrl_t              ctrl_ff;
    bus_state_t         bus_ff;
    logic [9:0]         waddr_ff;
    logic [CNT_W-1:0]   cnt_ff;
    logic [1:0]         instr_div_ff;
    logic               mod_ff;
    pin_drive_t         pin_ff;
    pin_src_t           src_ff;
    logic [31:0]        rdata_ff;
    logic               ready_ff;

    logic               take;
    logic               is_crystal;
    logic               nxt_refclk;
    logic [CNT_W-1:0]   nxt_cnt;
    pin_src_t           nxt_src;
    pin_drive_t         nxt_pin;
    logic [31:0]        nxt_rdata;
    ctrl_t              live_ctrl;

    function automatic logic [CNT_W-1:0] div_mask(input logic [2:0] div);
        logic [CNT_W:0] one;
        one = {{CNT_W{1'b0}}, 1'b1} << div;
        return one[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction

    function automatic logic [CNT_W:0] div_thresh(input logic [2:0] div,
                                                 input logic [1:0] duty);
        logic [CNT_W+2:0] full;
        full = ({{(CNT_W+2){1'b0}}, 1'b1} << div) * {{(CNT_W+1){1'b0}}, duty};
        if (div == 3'h1 && duty != 2'h0)
            return {{CNT_W{1'b0}}, 1'b1};
        return full[CNT_W+2:2];
    endfunction

    function automatic logic [31:0] ctrl_word(input ctrl_t c);
        return {24'h0000_00, c};
    endfunction

    assign take       = hsel && htrans[1] && hready;
    assign is_crystal = (osc_mode != OSC_OTHER);

    // Write data arriving this cycle, seen by a read captured in the same cycle
    always_comb
    begin
        live_ctrl = ctrl_ff;
        if (bus_ff == BUS_WRITE && waddr_ff == `REFCLK_CTRL_OFFSET >> `REFCLK_ADDR_LSB)
            live_ctrl = ctrl_t'(hwdata[7:0]);
    end

    // Divided clock from the free-running counter
    always_comb
    begin
        nxt_cnt    = cnt_ff;
        nxt_refclk = 1'b0;
        if (ctrl_ff.refclk_module_on)
        begin
            nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            if (ctrl_ff.duty_select == 2'h0)
                nxt_refclk = 1'b0;
            else if (ctrl_ff.divide_select == 3'h0)
                nxt_refclk = 1'b1;
            else
                nxt_refclk = {1'b0, cnt_ff & div_mask(ctrl_ff.divide_select)}
                             < div_thresh(ctrl_ff.divide_select, ctrl_ff.duty_select);
        end
        else
        begin
            nxt_cnt = '0;
        end
    end

    // Pin ownership
    always_comb
    begin
        nxt_src = PIN_RELEASED;
        if (is_crystal)
            nxt_src = PIN_RELEASED;
        else if (!instr_clock_out_ctrl)
            nxt_src = PIN_INSTR;
        else if (ctrl_ff.refclk_module_on && ctrl_ff.refclk_pin_route)
            nxt_src = PIN_REFCLK;
        nxt_pin.slew = ctrl_ff.pin_slew_limit;
        nxt_pin.oe   = (nxt_src != PIN_RELEASED);
        case (nxt_src)
            PIN_INSTR:  nxt_pin.out = instr_div_ff[1];
            PIN_REFCLK: nxt_pin.out = nxt_refclk;
            default:    nxt_pin.out = 1'b0;
        endcase
    end

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case ({haddr[`REFCLK_ADDR_MSB:`REFCLK_ADDR_LSB], 2'b00})
            `REFCLK_CTRL_OFFSET: nxt_rdata = ctrl_word(live_ctrl);
            `REFCLK_STAT_OFFSET:
            begin
                nxt_rdata[CNT_W-1:0] = cnt_ff;
                nxt_rdata[`REFCLK_STAT_SRC_LSB +: 2] = src_ff;
                nxt_rdata[`REFCLK_STAT_RUN_BIT] = ctrl_ff.refclk_module_on;
            end
            default:             nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Bus data-phase tracking
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_ff   <= BUS_IDLE;
            waddr_ff <= 10'h000;
        end
        else
        begin
            case (bus_ff)
                BUS_IDLE, BUS_READ, BUS_WRITE:
                begin
                    if (take)
                        bus_ff <= hwrite ? BUS_WRITE : BUS_READ;
                    else
                        bus_ff <= BUS_IDLE;
                end
                default: bus_ff <= BUS_IDLE;
            endcase
            if (take)
                waddr_ff <= haddr[`REFCLK_ADDR_MSB:`REFCLK_ADDR_LSB];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff <= 32'h0000_0000;
            ready_ff <= 1'b0;
        end
        else
        begin
            ready_ff <= 1'b1;
            if (take && !hwrite)
                rdata_ff <= nxt_rdata;
        end
    end

    // Control register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_ff <= ctrl_t'(`REFCLK_CTRL_RESET);
        else if (bus_ff == BUS_WRITE && waddr_ff == `REFCLK_CTRL_OFFSET >> `REFCLK_ADDR_LSB)
            ctrl_ff <= ctrl_t'(hwdata[7:0]);
    end

    // Clock generation, frozen while asleep
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff       <= '0;
            instr_div_ff <= 2'h0;
            mod_ff       <= 1'b0;
            pin_ff       <= '0;
            src_ff       <= PIN_RELEASED;
        end
        else if (!sleep_req)
        begin
            cnt_ff       <= nxt_cnt;
            instr_div_ff <= instr_div_ff + 2'h1;
            mod_ff       <= nxt_refclk;
            pin_ff       <= nxt_pin;
            src_ff       <= nxt_src;
        end
    end

    assign hreadyout          = ready_ff;
    assign hrdata             = rdata_ff;
    assign hresp              = 1'b0;
    assign modulator_clk      = mod_ff;
    assign refclk_pin_out     = pin_ff.out;
    assign refclk_pin_oe      = pin_ff.oe;
    assign pin_slew_limit_out = pin_ff.slew;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    crystal_no_drive_a: assert property (is_crystal && !sleep_req |=> !refclk_pin_oe)
        else $error("Pin driven in crystal mode");

    modulator_alive_a: assert property (
        (ctrl_ff.refclk_module_on && ctrl_ff.divide_select == 3'h1
         && ctrl_ff.duty_select == 2'h2 && !sleep_req)[*3]
        |-> modulator_clk != $past(modulator_clk))
        else $error("Modulator clock not toggling at divide by two");

    instr_priority_a: assert property (
        !is_crystal && !instr_clock_out_ctrl && !sleep_req
        |=> refclk_pin_oe && refclk_pin_out == $past(instr_div_ff[1]))
        else $error("Pin not carrying system clock by four");

    route_a: assert property (
        !is_crystal && instr_clock_out_ctrl && ctrl_ff.refclk_module_on
        && ctrl_ff.refclk_pin_route && !sleep_req
        |=> refclk_pin_oe && refclk_pin_out == modulator_clk)
        else $error("Reference clock not on pin");

    sleep_hold_a: assert property (sleep_req |=> $stable(modulator_clk)
        && $stable(refclk_pin_out) && $stable(refclk_pin_oe))
        else $error("Outputs moved during sleep");

    disable_low_a: assert property (!ctrl_ff.refclk_module_on && !sleep_req
        |=> !modulator_clk && cnt_ff == '0)
        else $error("Disabled module still running");

    slew_follow_a: assert property (!sleep_req |=>
        pin_slew_limit_out == $past(ctrl_ff.pin_slew_limit))
        else $error("Slew limit not following control");

    zero_duty_a: assert property (
        ctrl_ff.refclk_module_on && ctrl_ff.duty_select == 2'h0 && !sleep_req
        |=> !modulator_clk)
        else $error("Output high at zero duty");

    undivided_a: assert property (
        ctrl_ff.refclk_module_on && ctrl_ff.divide_select == 3'h0
        && ctrl_ff.duty_select != 2'h0 && !sleep_req |=> modulator_clk)
        else $error("Undivided output not high");

    div4_period_a: assert property (
        ($rose(modulator_clk) && ctrl_ff.divide_select == 3'h2 && ctrl_ff.duty_select == 2'h2)
        ##1 (ctrl_ff.divide_select == 3'h2 && ctrl_ff.duty_select == 2'h2
             && ctrl_ff.refclk_module_on && !sleep_req)[*4]
        |-> $rose(modulator_clk) && $past(modulator_clk, 3) && !$past(modulator_clk, 2))
        else $error("Divide by four period or duty wrong");

    crystal_mod_c: cover property (is_crystal && ctrl_ff.refclk_module_on && $rose(modulator_clk));
    instr_pin_c: cover property (!is_crystal && !instr_clock_out_ctrl ##1 $rose(refclk_pin_out));
    div128_c: cover property (src_ff == PIN_REFCLK && ctrl_ff.divide_select == 3'h7
        && $rose(refclk_pin_out));
    sleep_c: cover property (modulator_clk && sleep_req [*3]);

endmodule

//--- test/refclk_consumer.sv
// Consumer of a divided clock: counts high samples and rising edges over 128 cycles.
// Assumes sig is synchronous to clk and start is a one-cycle pulse.
`timescale 1ns/1ps

module refclk_consumer
(
    input  wire logic       clk,
    input  wire logic       sig,
    input  wire logic       start,
    output logic [7:0]      hi_ff,
    output logic [7:0]      rise_ff,
    output logic            done_ff
);
    logic [7:0] n_ff;
    logic       last_ff;

    always_ff @(posedge clk)
    begin
        done_ff <= 1'b0;
        last_ff <= sig;
        if (start)
        begin
            n_ff    <= 8'h80;
            hi_ff   <= 8'h00;
            rise_ff <= 8'h00;
        end
        else if (n_ff != 8'h00)
        begin
            n_ff    <= n_ff - 8'h01;
            hi_ff   <= hi_ff + 8'(sig);
            rise_ff <= rise_ff + 8'(sig & ~last_ff);
            done_ff <= (n_ff == 8'h01);
        end
    end
endmodule

//--- test/reference_clock_divider_tb_top.sv
// Bench: AHB-Lite master, queued expectations, consumer model on clock and pin.
// Assumes zero-wait answers and a pulled-down pin while undriven.
`timescale 1ns/1ps
`include "refclk_cfg.svh"

module reference_clock_divider_tb_top
    import refclk_pkg::*;
;
    localparam logic [31:0] CTRL_A = 32'(`REFCLK_CTRL_OFFSET);
    localparam logic [31:0] STAT_A = 32'(`REFCLK_STAT_OFFSET);
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic        instr, sleep_req, start, pin_sel, rd_pend;
    logic        mod_clk, pin_out, pin_oe, slew, done;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, seed;
    logic [7:0]  hi, rise;
    osc_mode_t   osc_mode;
    int          bad_count, total_checks;
    logic [31:0] exp_rd[$];
    logic [15:0] exp_ms[$];
    wire logic   pin_w = pin_oe ? pin_out : 1'b0;

    reference_clock_divider i_dut
    (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .osc_mode(osc_mode), .instr_clock_out_ctrl(instr),
        .sleep_req(sleep_req), .modulator_clk(mod_clk),
        .refclk_pin_out(pin_out), .refclk_pin_oe(pin_oe),
        .pin_slew_limit_out(slew)
    );

    refclk_consumer i_cons
    (
        .clk(clk), .sig(pin_sel ? pin_w : mod_clk), .start(start),
        .hi_ff(hi), .rise_ff(rise), .done_ff(done)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [15:0] m_exp(input logic [2:0] dv, input logic [1:0] dt);
        if (dt == 2'h0)
            return 16'h0000;
        if (dv == 3'h0)
            return 16'h8000;
        if (dv == 3'h1)
            return 16'h4040;
        return {1'b0, dt, 5'h00, 8'h80 >> dv};
    endfunction

    task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic meas(input logic sel, input logic [15:0] e);
        pin_sel <= sel;
        repeat (4) @(posedge clk);
        exp_ms.push_back(e);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (130) @(posedge clk);
    endtask

    always @(posedge clk)
        if (hreadyout === 1'b1)
            rd_pend <= hsel & htrans[1] & ~hwrite;

    always @(negedge clk)
    begin
        if (rd_pend === 1'b1 && hreadyout === 1'b1)
            check_eq(hrdata, exp_rd.pop_front());
        if (done === 1'b1)
            check_eq({16'h0000, hi, rise}, {16'h0000, exp_ms.pop_front()});
    end

    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        osc_mode = OSC_OTHER;
        instr = 1'b0;
        sleep_req = 1'b0;
        start = 1'b0;
        pin_sel = 1'b0;
        seed = 32'h0000_0042;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(CTRL_A, 32'h0000_0030);
        rd(STAT_A, 32'h0000_0100);
        rd(32'h0000_0010, 32'h0000_0000);
        repeat (4)
        begin
            seed = xs(seed);
            bus(1'b1, CTRL_A, seed);
            rd(CTRL_A, {24'h00_0000, seed[7:0]});
        end
        meas(1'b1, 16'h4020);
        instr <= 1'b1;
        for (int dv = 0; dv < 8; dv++)
            for (int dt = 0; dt < 4; dt++)
            begin
                bus(1'b1, CTRL_A, {24'h00_0000, 3'h4, 2'(dt), 3'(dv)});
                meas(1'b0, m_exp(3'(dv), 2'(dt)));
            end
        bus(1'b1, CTRL_A, 32'h0000_00DA);
        meas(1'b1, 16'h6020);
        check_eq(32'(slew), 32'h0000_0000);
        check_eq(32'(hresp), 32'h0000_0000);
        for (int m = 1; m < 4; m++)
        begin
            osc_mode <= osc_mode_t'(2'(m));
            meas(1'b1, 16'h0000);
            check_eq(32'(pin_oe), 32'h0000_0000);
            meas(1'b0, 16'h6020);
        end
        osc_mode <= OSC_OTHER;
        bus(1'b1, CTRL_A, 32'h0000_00BA);
        meas(1'b1, 16'h0000);
        check_eq(32'(slew), 32'h0000_0001);
        bus(1'b1, CTRL_A, 32'h0000_0090);
        repeat (4) @(posedge clk);
        sleep_req <= 1'b1;
        bus(1'b1, CTRL_A, 32'h0000_0000);
        meas(1'b0, 16'h8000);
        sleep_req <= 1'b0;
        meas(1'b0, 16'h0000);
        bus(1'b1, CTRL_A, 32'h0000_00FF);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check_eq(32'(mod_clk), 32'h0000_0000);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(CTRL_A, 32'h0000_0030);
        rd(STAT_A, 32'h0000_0000);
        repeat (4) @(posedge clk);
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule
